// ===== src/typec_cc_detect_toggle.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Any fixed comparator change raises level-code and threshold-match interrupts.
// - A 6-bit DAC threshold is compared against the selected line.
// - Bus power validity is reported; DAC may measure bus power instead.
// - Autonomous toggle drives pulls and measure selects, alternating source and sink.
// - Toggle may present source only or sink only, polling both lines.
// - On resolution, raise role-resolved interrupt and report role and orientation.
// - Toggle runs only while enable is 1; otherwise manual configuration applies.
// - Reading interrupts clears pending flags; processor reads before enabling toggle.
// - Bus power valid reads 1 attached, 0 detached; each change interrupts.
// - Sink level code maps Ra, default, 1.5 A, 3.0 A.
// - Advert change applies at attach if detached, immediately if attached.
// - Pending unmasked interrupts pull the open-drain interrupt line low.
// - Cable power is routed to the line chosen by two select bits.
module typec_cc_detect_toggle
   import cc_detect_pkg::*;
#(
   parameter int SLOT_CYCLES = POLL_SLOT_CYCLES
)
(
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic [2:0]          cc_threshold_pin,
   input  wire logic                dac_above_pin,
   input  wire logic                bus_power_pin,
   input  wire logic                toggle_enable,
   input  wire logic [1:0]          toggle_mode,
   input  wire logic [DAC_W-1:0]    dac_threshold,
   input  wire logic                measure_bus_power_select,
   input  wire logic [ADVERT_W-1:0] source_current_advert,
   input  wire logic                port_attached,
   input  wire logic                cable_power_to_line1,
   input  wire logic                cable_power_to_line2,
   input  wire logic [PWR_W-1:0]    power_domain_enables,
   input  wire logic                man_line1_pullup,
   input  wire logic                man_line2_pullup,
   input  wire logic                man_line1_pulldown,
   input  wire logic                man_line2_pulldown,
   input  wire logic                man_line1_measure,
   input  wire logic                man_line2_measure,
   input  wire logic [IRQ_W-1:0]    irq_mask,
   input  wire logic                irq_read,
   output logic                     line1_pullup_enable,
   output logic                     line2_pullup_enable,
   output logic                     line1_pulldown_enable,
   output logic                     line2_pulldown_enable,
   output logic                     line1_measure_select,
   output logic                     line2_measure_select,
   output logic                     dac_measure_bus,
   output logic [DAC_W-1:0]         dac_code,
   output logic [ADVERT_W-1:0]      applied_advert,
   output logic                     vconn_line1_on,
   output logic                     vconn_line2_on,
   output logic [PWR_W-1:0]         power_enable_out,
   output logic [LEVEL_W-1:0]       cc_level_code,
   output logic                     threshold_match,
   output logic                     bus_power_valid,
   output logic [ROLE_W-1:0]        role_resolved_state,
   output logic [IRQ_W-1:0]         irq_pending,
   output logic                     int_n_out,
   output logic                     int_n_oe
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [SYNC_W-1:0]   sync1_reg;
   logic [SYNC_W-1:0]   sync2_reg;
   logic [LEVEL_W-1:0]  level_next;
   logic                attached;
   logic                tog_pullup;
   logic                tog_pulldown;
   logic                tog_line2;
   logic                done_pulse;
   logic [ROLE_W-1:0]   role_state;
   logic [IRQ_W-1:0]    irq_set;

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++)
      begin : g_sync
         logic pin;
         if (g <= SY_THR2)
            assign pin = cc_threshold_pin[g];
         else if (g == SY_DAC)
            assign pin = dac_above_pin;
         else
            assign pin = bus_power_pin;
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               sync1_reg[g] <= 1'b0;
               sync2_reg[g] <= 1'b0;
            end
            else
            begin
               sync1_reg[g] <= pin;
               sync2_reg[g] <= sync1_reg[g];
            end
         end
      end
   endgenerate

   // Thermometer of three fixed comparators to a level code
   function automatic logic [LEVEL_W-1:0] therm_to_level(input logic [2:0] t);
      if (t[2])
         return LVL_3A0;
      else if (t[1])
         return LVL_1A5;
      else if (t[0])
         return LVL_USB;
      else
         return LVL_RA;
   endfunction

   assign level_next = therm_to_level({sync2_reg[SY_THR2], sync2_reg[SY_THR1],
                                       sync2_reg[SY_THR0]});

   // ------------------------------------------------------------
   // Status
   // ------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cc_level_code   <= LVL_RA;
         threshold_match <= 1'b0;
         bus_power_valid <= 1'b0;
      end
      else
      begin
         cc_level_code   <= level_next;
         threshold_match <= sync2_reg[SY_DAC];
         bus_power_valid <= sync2_reg[SY_VBUS];
      end
   end

   // ------------------------------------------------------------
   // Toggle engine and line control
   // ------------------------------------------------------------
   role_toggle_fsm #(
      .SLOT_CYCLES (SLOT_CYCLES)
   ) role_toggle_fsm_inst (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .toggle_enable (toggle_enable),
      .toggle_mode   (toggle_mode),
      .level_code    (cc_level_code),
      .tog_pullup    (tog_pullup),
      .tog_pulldown  (tog_pulldown),
      .tog_line2     (tog_line2),
      .role_state    (role_state),
      .done_pulse    (done_pulse)
   );

   assign role_resolved_state = role_state;
   assign attached = port_attached || (role_state != ROLE_NONE);

   // Both pulls of the polled role stay on; only the measured line walks
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         line1_pullup_enable   <= 1'b0;
         line2_pullup_enable   <= 1'b0;
         line1_pulldown_enable <= 1'b0;
         line2_pulldown_enable <= 1'b0;
         line1_measure_select  <= 1'b0;
         line2_measure_select  <= 1'b0;
      end
      else if (toggle_enable)
      begin
         line1_pullup_enable   <= tog_pullup;
         line2_pullup_enable   <= tog_pullup;
         line1_pulldown_enable <= tog_pulldown;
         line2_pulldown_enable <= tog_pulldown;
         line1_measure_select  <= !tog_line2;
         line2_measure_select  <= tog_line2;
      end
      else
      begin
         line1_pullup_enable   <= man_line1_pullup;
         line2_pullup_enable   <= man_line2_pullup;
         line1_pulldown_enable <= man_line1_pulldown;
         line2_pulldown_enable <= man_line2_pulldown;
         line1_measure_select  <= man_line1_measure;
         line2_measure_select  <= man_line2_measure;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dac_code         <= '0;
         dac_measure_bus  <= 1'b0;
         vconn_line1_on   <= 1'b0;
         vconn_line2_on   <= 1'b0;
         power_enable_out <= '0;
      end
      else
      begin
         dac_code         <= dac_threshold;
         dac_measure_bus  <= measure_bus_power_select;
         vconn_line1_on   <= cable_power_to_line1;
         vconn_line2_on   <= cable_power_to_line2;
         power_enable_out <= power_domain_enables;
      end
   end

   // Detached changes are held back so a sink sees the new advert only at attach
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         applied_advert <= '0;
      else if (attached)
         applied_advert <= source_current_advert;
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   always_comb
   begin
      irq_set            = '0;
      irq_set[IRQ_LEVEL] = (level_next != cc_level_code);
      irq_set[IRQ_MATCH] = (level_next != cc_level_code)
                           || (sync2_reg[SY_DAC] != threshold_match);
      irq_set[IRQ_VBUS]  = (sync2_reg[SY_VBUS] != bus_power_valid);
      irq_set[IRQ_DONE]  = done_pulse;
   end

   // A read clears, but an event in the same cycle survives it
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         irq_pending <= '0;
      else
         irq_pending <= irq_set | (irq_read ? '0 : irq_pending);
   end

   assign int_n_out = 1'b0;
   assign int_n_oe  = |(irq_pending & ~irq_mask);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_level_change_irq: assert property ($changed(cc_level_code) |-> irq_pending[IRQ_LEVEL]
                                                && irq_pending[IRQ_MATCH])
      else $error("level change without interrupt");
   a_vbus_change_irq: assert property ($changed(bus_power_valid) |-> irq_pending[IRQ_VBUS])
      else $error("bus power change without interrupt");
   a_vbus_follows_pin: assert property (bus_power_pin [*3] |=> bus_power_valid)
      else $error("bus power valid lags pin");
   a_match_follows_pin: assert property (!dac_above_pin [*3] |=> !threshold_match)
      else $error("threshold match stuck high");
   a_int_line_mask: assert property (!int_n_oe ##1 (int_n_oe && $stable(irq_mask))
                                     |-> ($past(irq_set) & ~irq_mask) != '0)
      else $error("interrupt line raised without unmasked event");
   a_read_clears: assert property (irq_read && irq_set == '0 |=> irq_pending == '0)
      else $error("read did not clear flags");
   a_done_sets_irq: assert property ($rose(role_state != ROLE_NONE)
                                     |=> irq_pending[IRQ_DONE])
      else $error("role resolved without interrupt");
   a_manual_pulls: assert property (!toggle_enable [*2] |-> line1_pullup_enable
                                    == $past(man_line1_pullup))
      else $error("manual pull-up not applied");
   a_advert_attached: assert property (attached |=> applied_advert
                                       == $past(source_current_advert))
      else $error("advert not applied while attached");
   a_advert_held: assert property (!attached |=> $stable(applied_advert))
      else $error("advert changed while detached");
   a_vconn_route: assert property (##1 vconn_line2_on == $past(cable_power_to_line2))
      else $error("cable power route wrong");

   c_role_resolved: cover property ($rose(role_state != ROLE_NONE));
   c_irq_line: cover property ($rose(int_n_oe));
   c_vbus_attach: cover property ($rose(bus_power_valid));

endmodule // typec_cc_detect_toggle
`default_nettype wire

// ===== shared/cc_detect_pkg.sv
package cc_detect_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ          = 200;
   localparam int POLL_SLOT_US     = 1000;
   localparam int POLL_SLOT_CYCLES = POLL_SLOT_US * CLK_MHZ;

   // ------------------------------------------------------------
   // Widths and codes
   // ------------------------------------------------------------
   localparam int DAC_W     = 6;
   localparam int LEVEL_W   = 2;
   localparam int ADVERT_W  = 2;
   localparam int PWR_W     = 4;
   localparam int ROLE_W    = 3;
   localparam int IRQ_W     = 4;
   localparam int SYNC_W    = 5;

   localparam logic [LEVEL_W-1:0] LVL_RA     = 2'h0;
   localparam logic [LEVEL_W-1:0] LVL_USB    = 2'h1;
   localparam logic [LEVEL_W-1:0] LVL_1A5    = 2'h2;
   localparam logic [LEVEL_W-1:0] LVL_3A0    = 2'h3;

   // Interrupt flag positions
   localparam int IRQ_LEVEL = 0;
   localparam int IRQ_MATCH = 1;
   localparam int IRQ_VBUS  = 2;
   localparam int IRQ_DONE  = 3;

   // Synchronised pin vector positions
   localparam int SY_THR0  = 0;
   localparam int SY_THR1  = 1;
   localparam int SY_THR2  = 2;
   localparam int SY_DAC   = 3;
   localparam int SY_VBUS  = 4;

   // Resolved role codes
   localparam logic [ROLE_W-1:0] ROLE_NONE     = 3'h0;
   localparam logic [ROLE_W-1:0] ROLE_SRC_CC1  = 3'h1;
   localparam logic [ROLE_W-1:0] ROLE_SRC_CC2  = 3'h2;
   localparam logic [ROLE_W-1:0] ROLE_SNK_CC1  = 3'h5;
   localparam logic [ROLE_W-1:0] ROLE_SNK_CC2  = 3'h6;

   // Toggle presentation modes
   localparam logic [1:0] TOG_DUAL     = 2'h1;
   localparam logic [1:0] TOG_SRC_ONLY = 2'h2;
   localparam logic [1:0] TOG_SNK_ONLY = 2'h3;

   typedef enum logic [1:0] {TOG_IDLE, TOG_SRC, TOG_SNK, TOG_DONE} toggle_state_t;

endpackage

// ===== src/role_toggle_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module role_toggle_fsm
   import cc_detect_pkg::*;
#(
   parameter int SLOT_CYCLES = POLL_SLOT_CYCLES
)
(
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic                toggle_enable,
   input  wire logic [1:0]          toggle_mode,
   input  wire logic [LEVEL_W-1:0]  level_code,
   output logic                     tog_pullup,
   output logic                     tog_pulldown,
   output logic                     tog_line2,
   output logic [ROLE_W-1:0]        role_state,
   output logic                     done_pulse
);

   toggle_state_t      state_reg;
   logic [31:0]        slot_cnt_reg;
   logic               line_reg;
   logic               slot_end;
   logic               attach_seen;
   logic               snk_resolved;

   assign slot_end     = (slot_cnt_reg == 32'(SLOT_CYCLES - 1));
   // Resolved role stays presented; dropping it would look like a detach to the partner
   assign snk_resolved = (role_state == ROLE_SNK_CC1) || (role_state == ROLE_SNK_CC2);
   assign tog_pullup   = (state_reg == TOG_SRC) || (state_reg == TOG_DONE && !snk_resolved);
   assign tog_pulldown = (state_reg == TOG_SNK) || (state_reg == TOG_DONE && snk_resolved);
   assign tog_line2    = line_reg;

   // Source sees Rd only as a mid level; Ra (lowest) never resolves
   always_comb
   begin
      attach_seen = 1'b0;
      if (state_reg == TOG_SRC)
         attach_seen = (level_code == LVL_USB) || (level_code == LVL_1A5);
      else if (state_reg == TOG_SNK)
         attach_seen = (level_code != LVL_RA);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst || !toggle_enable || state_reg == TOG_IDLE || slot_end)
         slot_cnt_reg <= '0;
      else
         slot_cnt_reg <= slot_cnt_reg + 32'h1;
   end

   // Each role phase polls line 1 for a slot, then line 2
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || !toggle_enable || state_reg == TOG_IDLE)
         line_reg <= 1'b0;
      else if (slot_end && !attach_seen && state_reg != TOG_DONE)
         line_reg <= !line_reg;
   end

   always_ff @(posedge core_clk)
   begin
      done_pulse <= 1'b0;
      if (sys_rst || !toggle_enable)
      begin
         state_reg  <= TOG_IDLE;
         role_state <= ROLE_NONE;
      end
      else
      begin
         unique case (state_reg)
            TOG_IDLE:
               state_reg <= (toggle_mode == TOG_SNK_ONLY) ? TOG_SNK : TOG_SRC;
            TOG_SRC, TOG_SNK:
               if (slot_end && attach_seen)
               begin
                  state_reg  <= TOG_DONE;
                  done_pulse <= 1'b1;
                  if (state_reg == TOG_SRC)
                     role_state <= line_reg ? ROLE_SRC_CC2 : ROLE_SRC_CC1;
                  else
                     role_state <= line_reg ? ROLE_SNK_CC2 : ROLE_SNK_CC1;
               end
               else if (slot_end && line_reg && toggle_mode == TOG_DUAL)
                  state_reg <= (state_reg == TOG_SRC) ? TOG_SNK : TOG_SRC;
            TOG_DONE:
               state_reg <= TOG_DONE;
         endcase
      end
   end

endmodule // role_toggle_fsm
`default_nettype wire

// ===== sim/cc_port_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cc_port_partner
#(
   parameter logic [5:0] LVL_T0   = 6'h0a,
   parameter logic [5:0] LVL_T1   = 6'h14,
   parameter logic [5:0] LVL_T2   = 6'h28,
   parameter logic [5:0] BUS_CODE = 6'h3c,
   parameter int         LAG_NS   = 2
)
(
   input  wire logic       pullup1,
   input  wire logic       pullup2,
   input  wire logic       pulldown1,
   input  wire logic       pulldown2,
   input  wire logic       measure1,
   input  wire logic       measure2,
   input  wire logic       dac_on_bus,
   input  wire logic [5:0] dac_level,
   input  wire logic       far_on,
   input  wire logic       far_source,
   input  wire logic       far_line2,
   input  wire logic [5:0] far_volt,
   input  wire logic       vbus_on,
   output logic      [2:0] thermo_pins,
   output logic            dac_pin,
   output logic            vbus_pin
);
   // ------------------------------------------------------------
   // Line voltages seen by the comparators
   // ------------------------------------------------------------
   // A source partner shows up only against our pull-down, a sink only against our pull-up
   logic [5:0] volt1;
   logic [5:0] volt2;
   logic [5:0] meas;
   logic [5:0] seen;
   assign volt1 = (far_on && !far_line2 && (far_source ? pulldown1 : pullup1)) ? far_volt : 6'h00;
   assign volt2 = (far_on && far_line2 && (far_source ? pulldown2 : pullup2)) ? far_volt : 6'h00;
   assign meas  = measure1 ? volt1 : (measure2 ? volt2 : 6'h00);
   assign seen  = dac_on_bus ? (vbus_on ? BUS_CODE : 6'h00) : meas;
   initial
   begin
      thermo_pins = 3'h0;
      dac_pin     = 1'b0;
      vbus_pin    = 1'b0;
   end
   // Analog settling lag of 2 ns, kept inside half a clock of 2.5 ns
   always @(meas or seen or dac_level or vbus_on)
   begin
      thermo_pins <= #(LAG_NS) {meas >= LVL_T2, meas >= LVL_T1, meas >= LVL_T0};
      dac_pin     <= #(LAG_NS) (seen > dac_level);
      vbus_pin    <= #(LAG_NS) vbus_on;
   end
endmodule // cc_port_partner
`default_nettype wire

// ===== sim/tb_typec_cc_detect_toggle.sv
`timescale 1ns/1ps
`default_nettype none
module tb_typec_cc_detect_toggle;
   import cc_detect_pkg::*;
   localparam int LIMIT = 3000;
   typedef struct {int id; logic [15:0] exp; int due;} note_t;
   logic                core_clk, sys_rst, dac_above_pin, bus_power_pin, toggle_enable;
   logic                measure_bus_power_select, port_attached, irq_read, vc1, vc2;
   logic                cable_power_to_line1, cable_power_to_line2, dac_bus, int_n_out;
   logic                mpu1, mpu2, mpd1, mpd2, mm1, mm2, pu1, pu2, pd1, pd2, m1, m2;
   logic                threshold_match, bus_power_valid, int_n_oe, mt, mt_q;
   logic                far_on, far_source, far_line2, vbus_on;
   logic [2:0]          cc_threshold_pin;
   logic [1:0]          toggle_mode, lvl, lvl_q;
   logic [DAC_W-1:0]    dac_threshold, dac_code, far_volt;
   logic [ADVERT_W-1:0] source_current_advert, applied_advert;
   logic [PWR_W-1:0]    power_domain_enables, power_enable_out;
   logic [LEVEL_W-1:0]  cc_level_code;
   logic [ROLE_W-1:0]   role_resolved_state;
   logic [IRQ_W-1:0]    irq_mask, irq_pending, pend;
   logic [31:0]         r;
   int                  miscompares, n_checks, cyc, seed, n;
   note_t               notes[$];
   string               names[9] = '{"config", "pulls", "level", "pending", "role",
                                     "advert", "vbus", "toggle_pulls", "done"};
   logic [5:0]          volts[5] = '{6'h0f, 6'h1e, 6'h32, 6'h3c, 6'h05};
   logic [1:0]          tmode[3] = '{TOG_SNK_ONLY, TOG_SRC_ONLY, TOG_DUAL};
   logic [3:0]          tpull[3] = '{4'b0011, 4'b1100, 4'b0011};
   logic [2:0]          trole[3] = '{ROLE_SNK_CC2, ROLE_SRC_CC1, ROLE_SNK_CC1};

   typec_cc_detect_toggle #(.SLOT_CYCLES(8)) typec_cc_detect_toggle_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .cc_threshold_pin(cc_threshold_pin),
      .dac_above_pin(dac_above_pin), .bus_power_pin(bus_power_pin),
      .toggle_enable(toggle_enable), .toggle_mode(toggle_mode),
      .dac_threshold(dac_threshold), .measure_bus_power_select(measure_bus_power_select),
      .source_current_advert(source_current_advert), .port_attached(port_attached),
      .cable_power_to_line1(cable_power_to_line1), .cable_power_to_line2(cable_power_to_line2),
      .power_domain_enables(power_domain_enables), .man_line1_pullup(mpu1),
      .man_line2_pullup(mpu2), .man_line1_pulldown(mpd1), .man_line2_pulldown(mpd2),
      .man_line1_measure(mm1), .man_line2_measure(mm2), .irq_mask(irq_mask),
      .irq_read(irq_read), .line1_pullup_enable(pu1), .line2_pullup_enable(pu2),
      .line1_pulldown_enable(pd1), .line2_pulldown_enable(pd2),
      .line1_measure_select(m1), .line2_measure_select(m2), .dac_measure_bus(dac_bus),
      .dac_code(dac_code), .applied_advert(applied_advert), .vconn_line1_on(vc1),
      .vconn_line2_on(vc2), .power_enable_out(power_enable_out),
      .cc_level_code(cc_level_code), .threshold_match(threshold_match),
      .bus_power_valid(bus_power_valid), .role_resolved_state(role_resolved_state),
      .irq_pending(irq_pending), .int_n_out(int_n_out), .int_n_oe(int_n_oe));

   cc_port_partner cc_port_partner_inst (
      .pullup1(pu1), .pullup2(pu2), .pulldown1(pd1), .pulldown2(pd2), .measure1(m1),
      .measure2(m2), .dac_on_bus(dac_bus), .dac_level(dac_code), .far_on(far_on),
      .far_source(far_source), .far_line2(far_line2), .far_volt(far_volt),
      .vbus_on(vbus_on), .thermo_pins(cc_threshold_pin), .dac_pin(dac_above_pin),
      .vbus_pin(bus_power_pin));

   // ------------------------------------------------------------
   // Clock, cycle count, result monitor
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc >= LIMIT)
      begin
         miscompares++;
         wrap_up();
      end
   end
   function automatic logic [15:0] probe(input int id);
      case (id)
         0: probe = {3'h0, power_enable_out, vc2, vc1, dac_bus, dac_code};
         1: probe = {10'h0, pu1, pu2, pd1, pd2, m1, m2};
         2: probe = {13'h0, cc_level_code, threshold_match};
         3: probe = {11'h0, irq_pending, int_n_oe};
         4: probe = {13'h0, role_resolved_state};
         5: probe = {14'h0, applied_advert};
         6: probe = {14'h0, bus_power_valid, int_n_out};
         7: probe = {12'h0, pu1, pu2, pd1, pd2};
         default: probe = {14'h0, irq_pending[IRQ_DONE], int_n_oe};
      endcase
   endfunction
   // Notes are pushed in due order, so all ripe ones sit at the front of the queue
   always @(posedge core_clk)
   begin
      #1;
      while (notes.size() > 0 && notes[0].due <= cyc)
      begin
         check(names[notes[0].id], probe(notes[0].id), notes[0].exp);
         void'(notes.pop_front());
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic expect_at(input int id, input logic [15:0] exp, input int lag);
      notes.push_back('{id, exp, cyc + lag});
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   task automatic clear_irq();
      irq_read = 1'b1;
      expect_at(3, 16'h0, 1);
      step(1);
      irq_read = 1'b0;
   endtask
   task automatic cfg(input logic [12:0] v);
      {power_domain_enables, cable_power_to_line2, cable_power_to_line1,
       measure_bus_power_select, dac_threshold} = v;
      expect_at(0, {3'h0, v}, 1);
      step(1);
   endtask
   task automatic man(input logic [5:0] v);
      {mpu1, mpu2, mpd1, mpd2, mm1, mm2} = v;
      expect_at(1, {10'h0, v}, 1);
      step(1);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      seed = 32'h5117;
      {sys_rst, toggle_enable, measure_bus_power_select, port_attached, irq_read} = 5'h10;
      {cable_power_to_line1, cable_power_to_line2, mpu1, mpu2, mpd1, mpd2, mm1, mm2} = 8'h00;
      {far_on, far_source, far_line2, vbus_on, far_volt} = 10'h000;
      {dac_threshold, source_current_advert, power_domain_enables} = 12'h000;
      {toggle_mode, irq_mask, miscompares, n_checks, cyc} = {TOG_DUAL, 4'hf, 96'h0};
      step(12);
      sys_rst = 1'b0;
      expect_at(3, 16'h0, 1);
      expect_at(4, 16'h0, 1);
      step(1);
      repeat (4)
      begin
         r = $random(seed);
         cfg(r[12:0]);
         r = $random(seed);
         man(r[5:0]);
      end
      cfg({4'h7, 3'h0, 6'h34});
      man(6'b001010);
      {far_on, far_source, lvl_q, mt_q} = 5'b11000;
      step(4);
      clear_irq();
      foreach (volts[i])
      begin
         far_volt = volts[i];
         lvl = (volts[i] >= 6'h28) ? 2'h3 : (volts[i] >= 6'h14) ? 2'h2 : {1'b0, volts[i] >= 6'h0a};
         mt = volts[i] > 6'h34;
         pend = {2'b00, (lvl != lvl_q) || (mt != mt_q), lvl != lvl_q};
         irq_mask = i[0] ? 4'hf : 4'h0;
         expect_at(2, {13'h0, lvl, mt}, 3);
         expect_at(3, {11'h0, pend, |(pend & ~irq_mask)}, 3);
         step(3);
         clear_irq();
         {lvl_q, mt_q} = {lvl, mt};
      end
      irq_mask = 4'h0;
      vbus_on = 1'b1;
      expect_at(6, 16'h2, 3);
      expect_at(3, 16'h9, 3);
      step(3);
      clear_irq();
      measure_bus_power_select = 1'b1;
      expect_at(2, 16'h1, 4);
      step(4);
      clear_irq();
      measure_bus_power_select = 1'b0;
      step(5);
      clear_irq();
      vbus_on = 1'b0;
      expect_at(6, 16'h0, 3);
      expect_at(3, 16'h9, 3);
      step(3);
      clear_irq();
      source_current_advert = 2'h3;
      expect_at(5, 16'h0, 2);
      step(2);
      port_attached = 1'b1;
      expect_at(5, 16'h3, 1);
      step(1);
      source_current_advert = 2'h2;
      expect_at(5, 16'h2, 1);
      step(1);
      {port_attached, source_current_advert} = 3'b001;
      expect_at(5, 16'h2, 2);
      step(2);
      cfg({4'h7, 3'h0, 6'h26});
      man(6'b100010);
      {far_source, far_volt} = 7'h1e;
      expect_at(2, 16'h4, 3);
      step(3);
      far_volt = 6'h05;
      expect_at(2, 16'h0, 3);
      step(3);
      far_volt = 6'h3c;
      expect_at(2, 16'h7, 3);
      step(3);
      clear_irq();
      for (int t = 0; t < 3; t++)
      begin
         {far_on, far_source, far_line2} = {1'b1, t != 1, t == 0};
         far_volt = (t == 0) ? 6'h1e : 6'h0f;
         {mpu1, mpu2, mpd1, mpd2} = ~tpull[t];
         toggle_mode = tmode[t];
         irq_mask = 4'b0110;
         step(4);
         clear_irq();
         toggle_enable = 1'b1;
         n = 0;
         while (role_resolved_state === ROLE_NONE && n < 300)
         begin
            step(1);
            n++;
         end
         expect_at(4, {13'h0, trole[t]}, 1);
         expect_at(7, {12'h0, tpull[t]}, 1);
         expect_at(8, 16'h3, 1);
         if (t == 1)
            expect_at(5, 16'h1, 1);
         step(1);
         toggle_enable = 1'b0;
         expect_at(4, 16'h0, 1);
         expect_at(7, {12'h0, ~tpull[t]}, 1);
         step(2);
      end
      step(2);
      wrap_up();
   end
endmodule // tb_typec_cc_detect_toggle
`default_nettype wire
